//--- src/dfrs_top.sv
// Drive fault reaction sequencer with APB register file
`timescale 1ns/1ps
`include "dfrs_map.svh"
module dfrs_top
   import dfrs_pkg::*;
#(
   parameter int VW = 16
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // APB slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Fault detectors and speed feedback
   input  wire logic          fault_stb,
   input  wire logic [7:0]    fault_code,
   input  wire logic [VW-1:0] vel_mag,
   // Power stage and brake
   output logic               pwr_en,
   output logic               brake_apply,
   output logic               decel_active,
   output logic [15:0]        decel_limit
);
   // ------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------
   dfrs_state_type state_r, state_nxt;
   logic        brkint_r, run_r, clr_r;
   logic [15:0] decel_r, brkvel_r, brkdly_r, rampto_r;
   logic        warn_r;
   logic [7:0]  warn_code_r;
   logic [7:0]  lf_code_r;
   logic [3:0]  lf_group_r;
   logic        lf_fatal_r, lf_valid_r;
   logic        pwr_r, brk_r, dec_r;
   logic [15:0] dlim_r;
   logic [31:0] prdata_r;
   logic        pready_r, pslverr_r;
   logic [5:0]  tick_cnt_r;

   // ------------------------------------------------------------
   // Classification
   // ------------------------------------------------------------
   dfrs_cls_if cls ();
   assign cls.code = fault_code;
   dfrs_classify u_cls (.c(cls));

   wire f_fatal = fault_stb && cls.fatal;
   wire f_nonf  = fault_stb && cls.nonfatal;
   wire f_warn  = fault_stb && cls.warn;

   // ------------------------------------------------------------
   // Timers
   // ------------------------------------------------------------
   wire tick = (tick_cnt_r == 6'(`DFRS_TICK_CYC - 1));
   wire enter_ramp = (state_r == ST_IDLE) && f_nonf && !f_fatal;
   wire below_thr  = (vel_mag < VW'(brkvel_r));
   wire ramp_done, brk_done;
   wire enter_brk  = (state_r == ST_RAMP) && !f_fatal && below_thr;

   dfrs_timer #(.W(16)) u_ramp_tmr (
      .mclk  (mclk),
      .rst   (rst),
      .start (enter_ramp),
      .stop  (state_r != ST_RAMP && !enter_ramp),
      .tick  (tick),
      .load  (rampto_r),
      .done  (ramp_done)
   );

   dfrs_timer #(.W(16)) u_brk_tmr (
      .mclk  (mclk),
      .rst   (rst),
      .start (enter_brk),
      .stop  (state_r != ST_BRKWAIT && !enter_brk),
      .tick  (tick),
      .load  (brkdly_r),
      .done  (brk_done)
   );

   // ------------------------------------------------------------
   // Reaction sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (f_fatal)
               state_nxt = ST_FAULTED;
            else if (f_nonf)
               state_nxt = ST_RAMP;
         end
         ST_RAMP: begin
            if (f_fatal)
               state_nxt = ST_FAULTED;
            else if (below_thr)
               state_nxt = ST_BRKWAIT;
            else if (ramp_done)
               state_nxt = ST_FAULTED;
         end
         ST_BRKWAIT: begin
            if (f_fatal || brk_done)
               state_nxt = ST_FAULTED;
         end
         ST_FAULTED: begin
            if (clr_r && !fault_stb)
               state_nxt = ST_IDLE;
         end
      endcase
   end

   // Brake command: set only when brake control is internal, released on the faulted to idle return in either mode
   wire brk_set = brkint_r && (
                  (state_nxt == ST_FAULTED && state_r != ST_FAULTED) ||
                  (state_nxt == ST_BRKWAIT && state_r == ST_RAMP));
   wire brk_rel = (state_r == ST_FAULTED) && (state_nxt == ST_IDLE);
   // Clear request returns to 0 once the idle state is reached
   wire clr_done = (state_nxt == ST_IDLE) || (state_r == ST_IDLE);

   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r    <= ST_IDLE;
         pwr_r      <= 1'b0;
         brk_r      <= 1'b0;
         dec_r      <= 1'b0;
         dlim_r     <= 16'h0000;
         tick_cnt_r <= 6'h00;
      end else begin
         state_r    <= state_nxt;
         tick_cnt_r <= tick ? 6'h00 : tick_cnt_r + 6'h01;
         pwr_r      <= (state_nxt == ST_IDLE) ? run_r :
                       (state_nxt != ST_FAULTED);
         if (brk_set)
            brk_r <= 1'b1;
         else if (brk_rel)
            brk_r <= 1'b0;
         dec_r  <= (state_nxt == ST_RAMP);
         dlim_r <= (state_nxt == ST_RAMP) ? decel_r : 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Fault and warning log
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         lf_code_r   <= 8'h00;
         lf_group_r  <= 4'h0;
         lf_fatal_r  <= 1'b0;
         lf_valid_r  <= 1'b0;
         warn_r      <= 1'b0;
         warn_code_r <= 8'h00;
      end else begin
         if (fault_stb && !cls.warn) begin
            lf_code_r  <= fault_code;
            lf_group_r <= cls.group;
            lf_fatal_r <= cls.fatal;
            lf_valid_r <= 1'b1;
         end
         if (f_warn) begin
            warn_r      <= 1'b1;
            warn_code_r <= fault_code;
         end else if (brk_rel) begin
            warn_r <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   wire setup  = psel && !penable;
   wire wr_acc = psel && penable && pwrite && pready_r;
   wire a_ctrl = (paddr == `DFRS_OFS_CTRL);
   wire a_stat = (paddr == `DFRS_OFS_STATUS);
   wire a_lf   = (paddr == `DFRS_OFS_LASTF);
   wire a_dec  = (paddr == `DFRS_OFS_DECEL);
   wire a_bv   = (paddr == `DFRS_OFS_BRKVEL);
   wire a_bd   = (paddr == `DFRS_OFS_BRKDLY);
   wire a_rt   = (paddr == `DFRS_OFS_RAMPTO);
   wire a_hit  = a_ctrl | a_stat | a_lf | a_dec | a_bv | a_bd | a_rt;

   wire [31:0] rd_ctrl = {29'h0, clr_r, run_r, brkint_r};
   wire [31:0] rd_stat = {16'h0, warn_code_r, 2'h0, warn_r, brk_r,
                          pwr_r, state_r};
   wire [31:0] rd_lf   = {18'h0, lf_valid_r, lf_fatal_r, lf_group_r,
                          lf_code_r};
   wire [31:0] rd_mux  = a_ctrl ? rd_ctrl :
                         a_stat ? rd_stat :
                         a_lf   ? rd_lf   :
                         a_dec  ? {16'h0, decel_r}  :
                         a_bv   ? {16'h0, brkvel_r} :
                         a_bd   ? {16'h0, brkdly_r} :
                         a_rt   ? {16'h0, rampto_r} : 32'h0;

   always_ff @(posedge mclk) begin
      if (rst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup && !a_hit;
         prdata_r  <= (setup && !pwrite) ? rd_mux : 32'h0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         brkint_r <= `DFRS_RST_BRKINT;
         run_r    <= 1'b0;
         clr_r    <= 1'b0;
         decel_r  <= `DFRS_RST_DECEL;
         brkvel_r <= `DFRS_RST_BRKVEL;
         brkdly_r <= `DFRS_RST_BRKDLY;
         rampto_r <= `DFRS_RST_RAMPTO;
      end else begin
         if (wr_acc && a_ctrl) begin
            brkint_r <= pwdata[`DFRS_CTRL_BRKINT];
            run_r    <= pwdata[`DFRS_CTRL_RUN];
         end
         if (wr_acc && a_ctrl && pwdata[`DFRS_CTRL_CLR])
            clr_r <= 1'b1;
         else if (clr_done)
            clr_r <= 1'b0;
         if (wr_acc && a_dec)
            decel_r <= pwdata[15:0];
         if (wr_acc && a_bv)
            brkvel_r <= pwdata[15:0];
         if (wr_acc && a_bd)
            brkdly_r <= pwdata[15:0];
         if (wr_acc && a_rt)
            rampto_r <= pwdata[15:0];
      end
   end

   assign prdata       = prdata_r;
   assign pready       = pready_r;
   assign pslverr      = pslverr_r;
   assign pwr_en       = pwr_r;
   assign brake_apply  = brk_r;
   assign decel_active = dec_r;
   assign decel_limit  = dlim_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_fatal_disable: assert property (
      @(posedge mclk) disable iff (rst)
      f_fatal |=> !pwr_en && state_r == ST_FAULTED)
      else $error("power stays on after fatal fault");
   chk_fatal_brake: assert property (
      @(posedge mclk) disable iff (rst)
      f_fatal && brkint_r && state_r != ST_FAULTED |=> brake_apply)
      else $error("brake not applied on fatal fault");
   chk_ext_brake: assert property (
      @(posedge mclk) disable iff (rst)
      !brkint_r && state_r != ST_FAULTED |=> $stable(brake_apply))
      else $error("brake moved under external control");
   chk_ramp_start: assert property (
      @(posedge mclk) disable iff (rst)
      enter_ramp |=> decel_active && decel_limit == decel_r && pwr_en)
      else $error("ramp not started on non-fatal fault");
   chk_brake_thr: assert property (
      @(posedge mclk) disable iff (rst)
      enter_brk |=> state_r == ST_BRKWAIT && brake_apply == brkint_r)
      else $error("brake not applied below threshold");
   chk_brake_wait: assert property (
      @(posedge mclk) disable iff (rst)
      state_r == ST_BRKWAIT && !brk_done && !f_fatal |=> pwr_en)
      else $error("power dropped before brake delay");
   chk_ramp_tmo: assert property (
      @(posedge mclk) disable iff (rst)
      state_r == ST_RAMP && ramp_done && !below_thr |=>
      !pwr_en && (brake_apply || !brkint_r))
      else $error("ramp timeout did not disable");
   chk_warn_only: assert property (
      @(posedge mclk) disable iff (rst)
      f_warn && state_r == ST_IDLE |=> state_r == ST_IDLE && warn_r)
      else $error("warning started a reaction");
   chk_fatal_abort: assert property (
      @(posedge mclk) disable iff (rst)
      state_r == ST_RAMP && f_fatal |=> !decel_active && !pwr_en)
      else $error("ramp not aborted by fatal fault");
   chk_class_excl: assert property (
      @(posedge mclk) disable iff (rst)
      fault_stb |-> $onehot({cls.fatal, cls.nonfatal, cls.warn}))
      else $error("fault code has no single class");
   chk_fault_hold: assert property (
      @(posedge mclk) disable iff (rst)
      state_r == ST_FAULTED |-> !pwr_en && !decel_active)
      else $error("power or ramp active while faulted");
   chk_ramp_hold: assert property (
      @(posedge mclk) disable iff (rst)
      state_r == ST_RAMP |-> decel_active && pwr_en)
      else $error("ramp state without ramp outputs");
   chk_limit_idle: assert property (
      @(posedge mclk) disable iff (rst)
      state_r != ST_RAMP |-> !decel_active && decel_limit == 16'h0000)
      else $error("ramp outputs active outside ramp");
   chk_nf_ext_brake: assert property (
      @(posedge mclk) disable iff (rst)
      enter_brk && !brkint_r |=> !brake_apply)
      else $error("brake driven under external control");
   chk_wait_abort: assert property (
      @(posedge mclk) disable iff (rst)
      state_r == ST_BRKWAIT && f_fatal |=> state_r == ST_FAULTED && !pwr_en)
      else $error("brake wait not aborted by fatal fault");
   chk_log_entry: assert property (
      @(posedge mclk) disable iff (rst)
      fault_stb && !cls.warn |=>
      lf_valid_r && lf_code_r == $past(fault_code))
      else $error("fault not logged");
   chk_warn_code: assert property (
      @(posedge mclk) disable iff (rst)
      f_warn |=> warn_code_r == $past(fault_code))
      else $error("warning code not logged");
   chk_clear_return: assert property (
      @(posedge mclk) disable iff (rst)
      clr_r && state_r == ST_IDLE && !(wr_acc && a_ctrl) |=> !clr_r)
      else $error("clear request not returned to 0");
endmodule

//--- src/dfrs_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DFRS_MAP_SVH
`define DFRS_MAP_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define DFRS_OFS_CTRL      8'h00
`define DFRS_OFS_STATUS    8'h04
`define DFRS_OFS_LASTF     8'h08
`define DFRS_OFS_DECEL     8'h0C
`define DFRS_OFS_BRKVEL    8'h10
`define DFRS_OFS_BRKDLY    8'h14
`define DFRS_OFS_RAMPTO    8'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DFRS_CTRL_BRKINT   0
`define DFRS_CTRL_RUN      1
`define DFRS_CTRL_CLR      2
`define DFRS_ST_PWR        3
`define DFRS_ST_BRK        4
`define DFRS_ST_WARN       5
`define DFRS_LF_FATAL      12
`define DFRS_LF_VALID      13

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define DFRS_RST_BRKINT    1'h1
`define DFRS_RST_DECEL     16'h0100
`define DFRS_RST_BRKVEL    16'h0010
`define DFRS_RST_BRKDLY    16'h0064
`define DFRS_RST_RAMPTO    16'h07D0

// ------------------------------------------------------------
// Timing: timer tick period and clock period
// ------------------------------------------------------------
`define DFRS_TICK_NS       1000
`define DFRS_CLK_NS        25
`define DFRS_TICK_CYC      (`DFRS_TICK_NS / `DFRS_CLK_NS)

`endif

//--- src/dfrs_pkg.sv
// Types shared by the fault reaction sequencer
package dfrs_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RAMP,
      ST_BRKWAIT,
      ST_FAULTED
   } dfrs_state_type;
endpackage

//--- src/dfrs_cls_if.sv
// Fault code to class signals between top and classifier
`timescale 1ns/1ps
interface dfrs_cls_if;
   logic [7:0] code;
   logic [3:0] group;
   logic       fatal;
   logic       nonfatal;
   logic       warn;
   modport cls  (input code, output group, fatal, nonfatal, warn);
   modport user (output code, input group, fatal, nonfatal, warn);
endinterface

//--- src/dfrs_classify.sv
// Status code classifier: group and severity of each fault code
`timescale 1ns/1ps
module dfrs_classify
   import dfrs_pkg::*;
(
   // Code in, class out
   dfrs_cls_if.cls c
);
   always_comb begin
      c.group    = 4'h0;
      c.fatal    = 1'b0;
      c.nonfatal = 1'b0;
      c.warn     = 1'b0;
      unique case (c.code) inside
         8'h3D, 8'h49, 8'h4D: begin
            c.group = 4'h1; c.fatal = 1'b1; end
         8'h3A: begin c.group = 4'h2; c.fatal = 1'b1; end
         8'h3C, 8'h46: begin
            c.group = 4'h3; c.fatal = 1'b1; end
         8'h1A: begin c.group = 4'h4; c.nonfatal = 1'b1; end
         8'h4B: begin c.group = 4'h5; c.nonfatal = 1'b1; end
         8'h5E: begin c.group = 4'h5; c.fatal = 1'b1; end
         8'h4C: begin c.group = 4'h6; c.nonfatal = 1'b1; end
         8'h48, 8'h53, 8'h54, 8'h6A, 8'h6E: begin
            c.group = 4'h7; c.fatal = 1'b1; end
         8'h51, 8'h52: begin
            c.group = 4'h7; c.nonfatal = 1'b1; end
         8'h4A: begin c.group = 4'h8; c.fatal = 1'b1; end
         8'h40, 8'h42, 8'h43, 8'h44, 8'h47: begin
            c.group = 4'h9; c.fatal = 1'b1; end
         8'hA8, 8'h0D, 8'h7B: begin
            c.group = 4'hA; c.fatal = 1'b1; end
         8'h0C: begin c.group = 4'hA; c.nonfatal = 1'b1; end
         8'h05, 8'hB8, 8'hB9, 8'hBB, 8'hBC: begin
            c.group = 4'hB; c.fatal = 1'b1; end
         8'h06: begin c.group = 4'hB; c.nonfatal = 1'b1; end
         8'h45, 8'h3B: begin
            c.group = 4'hC; c.nonfatal = 1'b1; end
         8'h78, 8'h7A, [8'h7F:8'h83], [8'h90:8'hA6]: begin
            c.group = 4'hD; c.fatal = 1'b1; end
         8'h56: begin c.group = 4'hE; c.fatal = 1'b1; end
         8'h60, 8'h61: begin
            c.group = 4'hE; c.nonfatal = 1'b1; end
         8'h18, 8'h19, 8'h1D, 8'h20, 8'h26, 8'h28, 8'h2D, 8'h2E,
         8'h0F: begin
            c.group = 4'hF; c.fatal = 1'b1; end
         8'h41, 8'h5F: c.warn = 1'b1;
         default: c.fatal = 1'b1;
      endcase
   end
endmodule

//--- src/dfrs_timer.sv
// Tick driven one-shot down counter
`timescale 1ns/1ps
module dfrs_timer #(
   parameter int W = 16
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst,
   // Control
   input  wire logic         start,
   input  wire logic         stop,
   input  wire logic         tick,
   input  wire logic [W-1:0] load,
   // Status
   output logic              done
);
   logic [W-1:0] cnt_r;
   logic         run_r;

   assign done = run_r && (cnt_r == '0);

   always_ff @(posedge mclk) begin
      if (rst || stop) begin
         run_r <= 1'b0;
         cnt_r <= '0;
      end else if (start) begin
         run_r <= 1'b1;
         cnt_r <= load;
      end else if (run_r && tick && cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule

//--- tb/dfrs_motor_model.sv
// Behavioural motor shaft and holding brake on the far side
`timescale 1ns/1ps
module dfrs_motor_model #(
   parameter int VRUN = 1000
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Drive outputs
   input  wire logic        pwr_en,
   input  wire logic        brake_apply,
   input  wire logic        decel_active,
   input  wire logic [15:0] decel_limit,
   // Bench control: shaft ignores the ramp
   input  wire logic        stall,
   // Speed feedback
   output logic [15:0]      vel_mag
);
   // ----
   // Shaft speed
   // ----
   wire logic [15:0] step = {4'h0, decel_limit[15:4]};

   always_ff @(posedge mclk) begin
      if (rst) begin
         vel_mag <= 16'(VRUN);
      end else if (brake_apply) begin
         vel_mag <= 16'h0000;
      end else if (decel_active && !stall) begin
         vel_mag <= (vel_mag > step) ? vel_mag - step : 16'h0000;
      end else if (pwr_en && !decel_active) begin
         vel_mag <= 16'(VRUN);
      end
   end
endmodule

//--- tb/dfrs_top_test.sv
// Self-checking bench for the drive fault reaction sequencer
`timescale 1ns/1ps
`include "dfrs_map.svh"
module dfrs_top_test;
   // ----
   // Signals
   // ----
   localparam int TK = `DFRS_TICK_CYC;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        fault_stb = 1'b0;
   logic [7:0]  fault_code = 8'h00;
   logic        stall = 1'b0;
   logic [31:0] prdata, rv;
   logic        pready, pslverr, pwr_en, brake_apply, decel_active, re;
   logic [15:0] decel_limit, vel_mag;
   logic [12:0] tbl[$];
   int          error_cnt = 0;
   int          check_count = 0;
   int          cyc = 0;

   always #12.5 mclk = ~mclk;

   dfrs_top #(.VW(16)) dut (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .fault_stb(fault_stb), .fault_code(fault_code), .vel_mag(vel_mag),
      .pwr_en(pwr_en), .brake_apply(brake_apply),
      .decel_active(decel_active), .decel_limit(decel_limit));

   dfrs_motor_model motor (.mclk(mclk), .rst(rst), .pwr_en(pwr_en),
      .brake_apply(brake_apply), .decel_active(decel_active),
      .decel_limit(decel_limit), .stall(stall), .vel_mag(vel_mag));

   // ----
   // Shared tasks
   // ----
   task automatic chk(input string nm, input logic [31:0] exp, got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic fault(input logic [7:0] c);
      @(posedge mclk);
      fault_stb <= 1'b1;
      fault_code <= c;
      @(posedge mclk);
      fault_stb <= 1'b0;
      @(negedge mclk);
   endtask

   task automatic rearm(input logic brk);
      apb(1'b1, `DFRS_OFS_CTRL, {29'h0, 2'b11, brk});
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic wait_out(input bit brk, input logic v, output int n);
      n = 0;
      while ((brk ? brake_apply : pwr_en) !== v && n < 5000) begin
         @(negedge mclk);
         n++;
      end
   endtask

   // ----
   // Scenarios
   // ----
   task automatic t_reset();
      logic [7:0]  a[5] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h18};
      logic [31:0] e[5] = '{32'h1, 32'h100, 32'h10, 32'h64, 32'h7D0};
      chk("power after reset", 32'h0, 32'(pwr_en));
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, a[i], 32'h0);
         chk("reset value", e[i], rv);
      end
      apb(1'b1, 8'h1C, 32'hFFFF);
      chk("unmapped write error", 32'h1, 32'(re));
      apb(1'b0, 8'h1C, 32'h0);
      chk("unmapped read data", 32'h0, rv);
   endtask

   task automatic t_table();
      logic [12:0] e;
      for (int i = 0; i < tbl.size(); i++) begin
         e = tbl[i];
         rearm(1'b1);
         fault(e[7:0]);
         chk("power enable", 32'(!e[12]), 32'(pwr_en));
         chk("brake", 32'(e[12]), 32'(brake_apply));
         chk("ramp flag", 32'(!e[12]), 32'(decel_active));
         apb(1'b0, `DFRS_OFS_LASTF, 32'h0);
         chk("fault log", {18'h0, 1'b1, e}, rv);
         if (!e[12])
            fault(8'h3D);
      end
   endtask

   task automatic t_nonfatal();
      int n;
      apb(1'b1, `DFRS_OFS_BRKDLY, 32'h2);
      apb(1'b1, `DFRS_OFS_RAMPTO, 32'h14);
      rearm(1'b1);
      fault(8'h4C);
      chk("decel limit", 32'h100, 32'(decel_limit));
      wait_out(1'b1, 1'b1, n);
      chk("brake before timeout", 32'h1, 32'(n < 200));
      chk("below threshold", 32'h1, 32'(vel_mag < 16'h10));
      chk("ramp ended", 32'h0, 32'(decel_active));
      chk("limit after ramp", 32'h0, 32'(decel_limit));
      chk("power at brake", 32'h1, 32'(pwr_en));
      wait_out(1'b0, 1'b0, n);
      chk("brake delay", 32'h1, 32'(n >= TK && n <= 3*TK+2));
   endtask

   task automatic t_timeout();
      int n;
      apb(1'b1, `DFRS_OFS_RAMPTO, 32'h3);
      stall <= 1'b1;
      rearm(1'b1);
      fault(8'h1A);
      wait_out(1'b0, 1'b0, n);
      chk("ramp timeout", 32'h1, 32'(n >= 2*TK-2 && n <= 4*TK+2));
      chk("timeout brake", 32'h1, 32'(brake_apply));
      stall <= 1'b0;
      apb(1'b1, `DFRS_OFS_RAMPTO, 32'h14);
   endtask

   task automatic t_external();
      int n;
      rearm(1'b0);
      fault(8'h4A);
      chk("fatal ext power", 32'h0, 32'(pwr_en));
      chk("fatal ext brake", 32'h0, 32'(brake_apply));
      rearm(1'b0);
      fault(8'h0C);
      wait_out(1'b0, 1'b0, n);
      chk("ext disable", 32'h0, 32'(pwr_en));
      chk("ext brake", 32'h0, 32'(brake_apply));
   endtask

   task automatic t_abort();
      stall <= 1'b1;
      rearm(1'b1);
      fault(8'h60);
      chk("ramp running", 32'h1, 32'(decel_active));
      repeat (5) @(posedge mclk);
      fault(8'h56);
      chk("abort power", 32'h0, 32'(pwr_en));
      chk("abort brake", 32'h1, 32'(brake_apply));
      chk("abort ramp", 32'h0, 32'(decel_active));
      stall <= 1'b0;
   endtask

   task automatic t_warn();
      rearm(1'b1);
      fault(8'h41);
      fault(8'h5F);
      chk("warn power", 32'h1, 32'(pwr_en));
      chk("warn ramp", 32'h0, 32'(decel_active));
      apb(1'b0, `DFRS_OFS_STATUS, 32'h0);
      chk("warn status", 32'h5F20, rv & 32'hFF20);
      rearm(1'b1);
      apb(1'b0, `DFRS_OFS_CTRL, 32'h0);
      chk("clear returned", 32'h0, rv & 32'h4);
   endtask

   // ----
   // Main sequence and hang guard
   // ----
   initial begin
      tbl = '{13'h113D, 13'h1149, 13'h114D, 13'h123A,
         13'h133C, 13'h1346, 13'h041A, 13'h054B, 13'h155E,
         13'h064C, 13'h1748, 13'h0751, 13'h0752, 13'h1753,
         13'h1754, 13'h176A, 13'h176E, 13'h184A, 13'h1940,
         13'h1942, 13'h1943, 13'h1944, 13'h1947, 13'h1AA8,
         13'h0A0C, 13'h1A0D, 13'h1A7B, 13'h1B05, 13'h0B06,
         13'h1BB8, 13'h1BB9, 13'h1BBB, 13'h1BBC, 13'h0C45,
         13'h0C3B, 13'h1D78, 13'h1D7A, 13'h1E56, 13'h0E60,
         13'h0E61, 13'h1F18, 13'h1F19, 13'h1F1D, 13'h1F20,
         13'h1F26, 13'h1F28, 13'h1F2D, 13'h1F2E, 13'h1F0F};
      for (int c = 8'h7F; c <= 8'hA6; c++)
         if (c <= 8'h83 || c >= 8'h90)
            tbl.push_back(13'h1D00 | 13'(c));
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      t_reset();
      t_table();
      t_nonfatal();
      t_timeout();
      t_external();
      t_abort();
      t_warn();
      print_verdict();
   end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         $display("BAD run time expected under 60000 seen %0d", cyc);
         print_verdict();
      end
   end
endmodule
